/* File: src/srs_pkg.sv */
// Purpose: constants for the switch reset and strap control block
// Assumes: 32-bit apb register bus, 250 MHz core clock
// Notes: register offsets are byte addresses
package srs_pkg;
  // register map (byte addresses)
  localparam logic [11:0] SRS_SWITCH_CONTROL_REG_OFF = 12'h000; // switch control
  localparam logic [11:0] SRS_STRAP_OFF = 12'h004; // latched straps, read only
  localparam logic [11:0] SRS_USLS_OFF = 12'h008; // upstream link status
  localparam logic [11:0] SRS_DSLS0_OFF = 12'h00c; // first downstream link status
  localparam int SRS_NUM_DS = 2; // downstream ports
  // field positions
  localparam int SRS_HALT_BIT = 0; // switch control: reset halt
  localparam int SRS_SCLK_BIT = 12; // link status: slot clock configuration
  localparam int SRS_ST_MODE_LSB = 0; // strap reg: switch mode [2:0]
  localparam int SRS_ST_SLOW_BIT = 3; // strap reg: smbus slow
  localparam int SRS_ST_CCUS_BIT = 4;
  localparam int SRS_ST_CCDS_BIT = 5;
  localparam int SRS_ST_HALT_BIT = 6; // strap reg: halt strap seen
  localparam int SRS_ST_STATE_LSB = 8; // strap reg: sequencer state [3:0]
  localparam int SRS_ST_RSVD_BIT = 12; // strap reg: reserved mode seen
  // switch mode codes
  localparam logic [2:0] SRS_MODE_NORMAL = 3'h0;
  localparam logic [2:0] SRS_MODE_EEPROM = 3'h1;
  // smbus rates and the cycles per half period of the bus clock
  localparam int SRS_CLK_MHZ = 250;
  localparam int SRS_SLOW_KHZ = 100;
  localparam int SRS_FAST_KHZ = 400;
  localparam logic [11:0] SRS_SLOW_HALF = 12'((SRS_CLK_MHZ * 1000) / (2 * SRS_SLOW_KHZ));
  localparam logic [11:0] SRS_FAST_HALF = 12'((SRS_CLK_MHZ * 1000) / (2 * SRS_FAST_KHZ));
  // reset procedure length in cycles
  localparam logic [7:0] SRS_RST_PROC_CYC = 8'h10;
  typedef enum logic [3:0] {
    SRS_ST_RESET = 4'h1, // fundamental reset held
    SRS_ST_PROC = 4'h2, // reset procedure running
    SRS_ST_HALTED = 4'h4, // halted, smbus alive
    SRS_ST_RUN = 4'h8 // normal operation
  } srs_state_t;
endpackage

/* File: src/srs_top.sv */
// Purpose: fundamental reset, reset halt and strap sampling for a pcie switch
// Assumes: straps and reset pin synchronous to core_clk
// Notes: the halt bit is cleared by an smbus master writing switch control over apb
// Overview of operation
// - downstream slot clock bits load common-clock strap
// - upstream slot clock bit loads common-clock strap
// - slow strap gives 100 KHz, else 400 KHz
// - no register overrides master smbus speed
// - fundamental reset low holds all logic reset
// - halt strap stops after procedure, smbus alive
// - leaving halt only when halt bit cleared
// - decode switch mode strap, 2 to 7 reserved
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module srs_top
  import srs_pkg::*;
(
  input wire logic core_clk, // 250 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic fundamental_reset_n, // board fundamental reset, active low
  input wire logic reset_halt, // halt strap
  input wire logic [2:0] switch_mode_strap, // operating mode strap
  input wire logic master_smbus_slow_strap, // smbus slow strap
  input wire logic upstream_common_clock_strap, // upstream common clock
  input wire logic downstream_common_clock_strap, // downstream common clock
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic core_reset, // internal logic reset, active high
  output logic smbus_enable, // smbus interfaces alive
  output logic eeprom_init, // serial eeprom init requested
  output logic mode_reserved, // reserved mode strapped
  output logic smbus_clk_tick // master smbus half-period enable
);
  typedef struct packed {
    srs_state_t state;
    logic [7:0] proc_cnt;
    logic [2:0] mode;
    logic slow;
    logic cc_us;
    logic cc_ds;
    logic halt_strap;
    logic halt_bit;
    logic us_sclk;
    logic [SRS_NUM_DS-1:0] ds_sclk;
    logic [11:0] div_cnt;
    logic tick;
    logic [31:0] rdata;
    logic slverr;
    logic ack; // second access cycle, pready high
  } srs_regs_t;

  // sequencing in short:
  //   the fundamental reset pin low forces every register back to zero and
  //   parks the sequencer in the reset state, whatever was going on before.
  //   the first cycle with the pin high catches every strap into a flop;
  //   after that the strap pins are never looked at again, so a board that
  //   lets them wander after release cannot disturb a running switch.
  //   a fixed-length procedure follows; the smbus divider already runs
  //   during it, so that a halted switch can be reached over smbus.
  //   with the halt strap caught high the sequencer parks in the halted
  //   state until software clears the halt bit; it never goes back on its
  //   own, since a second halt needs another fundamental reset or rst.
  //
  // register access in short:
  //   every transfer takes one wait state. the first access cycle decodes
  //   the address and registers read data and the error flag; the second
  //   raises pready with both already standing in flops. a write lands at
  //   the edge that ends the second cycle, where the master samples pready.
  //   the trade is one extra cycle per access against a data path that
  //   leaves the block straight from flops, with no decode mux on prdata.

  srs_regs_t q_r;
  srs_regs_t q_nxt;
  logic wr_acc;
  logic rd_acc;
  logic acc_first;
  logic wr_bad;
  logic [11:0] half_cnt;
  logic [SRS_NUM_DS-1:0] ds_hit;

  // first access cycle decodes and registers the answer, second completes it
  assign acc_first = psel && penable && !q_r.ack;
  assign wr_acc = psel && penable && pwrite && q_r.ack;
  assign rd_acc = acc_first && !pwrite;
  // writes to unmapped words are refused; the strap word ignores writes quietly
  assign wr_bad = acc_first && pwrite && (paddr != SRS_SWITCH_CONTROL_REG_OFF) && (paddr != SRS_STRAP_OFF) &&
    (paddr != SRS_USLS_OFF) && !(|ds_hit);
  assign half_cnt = q_r.slow ? SRS_SLOW_HALF : SRS_FAST_HALF;

  // per downstream port address decode
  genvar gi;
  generate
    for (gi = 0; gi < SRS_NUM_DS; gi++) begin : g_ds
      assign ds_hit[gi] = (paddr == SRS_DSLS0_OFF + 12'(4 * gi));
    end
  endgenerate

  // next-state logic for sequencer, straps, registers and divider
  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    q_nxt.ack = acc_first; // pready follows one cycle after the access starts
    unique case (q_r.state)
      SRS_ST_RESET: begin
        // strap values are caught at the first cycle after the pin releases
        if (fundamental_reset_n) begin
          q_nxt.mode = switch_mode_strap;
          q_nxt.slow = master_smbus_slow_strap;
          q_nxt.cc_us = upstream_common_clock_strap;
          q_nxt.cc_ds = downstream_common_clock_strap;
          q_nxt.halt_strap = reset_halt;
          q_nxt.halt_bit = reset_halt;
          q_nxt.us_sclk = upstream_common_clock_strap;
          q_nxt.ds_sclk = {SRS_NUM_DS{downstream_common_clock_strap}};
          q_nxt.proc_cnt = 8'h00;
          q_nxt.state = SRS_ST_PROC;
        end
      end
      SRS_ST_PROC: begin
        q_nxt.proc_cnt = q_r.proc_cnt + 8'h01;
        if (q_r.proc_cnt == SRS_RST_PROC_CYC - 8'h01) begin
          q_nxt.state = q_r.halt_bit ? SRS_ST_HALTED : SRS_ST_RUN;
        end
      end
      SRS_ST_HALTED: begin
        if (!q_r.halt_bit) begin
          q_nxt.state = SRS_ST_RUN;
        end
      end
      SRS_ST_RUN: begin
      end
    endcase
    // smbus clock divider runs in every state but reset, the procedure included
    if (q_r.state != SRS_ST_RESET) begin
      if (q_r.div_cnt >= half_cnt - 12'h001) begin
        q_nxt.div_cnt = 12'h000;
        q_nxt.tick = 1'b1;
      end else begin
        q_nxt.div_cnt = q_r.div_cnt + 12'h001;
      end
    end
    // register writes; the halt bit only clears, it cannot re-halt
    q_nxt.slverr = wr_bad;
    if (wr_acc) begin
      if (paddr == SRS_SWITCH_CONTROL_REG_OFF) begin
        if (!pwdata[SRS_HALT_BIT]) begin
          q_nxt.halt_bit = 1'b0;
        end
      end else if (paddr == SRS_USLS_OFF) begin
        q_nxt.us_sclk = pwdata[SRS_SCLK_BIT];
      end else if (|ds_hit) begin
        for (int i = 0; i < SRS_NUM_DS; i++) begin
          if (ds_hit[i]) begin
            q_nxt.ds_sclk[i] = pwdata[SRS_SCLK_BIT];
          end
        end
      end
    end
    // read data; strap register is read only so speed cannot be overridden
    if (rd_acc) begin
      q_nxt.rdata = 32'h0;
      if (paddr == SRS_SWITCH_CONTROL_REG_OFF) begin
        q_nxt.rdata[SRS_HALT_BIT] = q_r.halt_bit;
      end else if (paddr == SRS_STRAP_OFF) begin
        q_nxt.rdata[SRS_ST_MODE_LSB +: 3] = q_r.mode;
        q_nxt.rdata[SRS_ST_SLOW_BIT] = q_r.slow;
        q_nxt.rdata[SRS_ST_CCUS_BIT] = q_r.cc_us;
        q_nxt.rdata[SRS_ST_CCDS_BIT] = q_r.cc_ds;
        q_nxt.rdata[SRS_ST_HALT_BIT] = q_r.halt_strap;
        q_nxt.rdata[SRS_ST_STATE_LSB +: 4] = q_r.state;
        q_nxt.rdata[SRS_ST_RSVD_BIT] = (q_r.mode > SRS_MODE_EEPROM);
      end else if (paddr == SRS_USLS_OFF) begin
        q_nxt.rdata[SRS_SCLK_BIT] = q_r.us_sclk;
      end else if (|ds_hit) begin
        for (int i = 0; i < SRS_NUM_DS; i++) begin
          if (ds_hit[i]) begin
            q_nxt.rdata[SRS_SCLK_BIT] = q_r.ds_sclk[i];
          end
        end
      end else begin
        q_nxt.slverr = 1'b1;
      end
    end
    // pin low puts everything back into reset, straps released
    if (!fundamental_reset_n) begin
      q_nxt = '0;
      q_nxt.state = SRS_ST_RESET;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_r <= '0;
      q_r.state <= SRS_ST_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // apb answers in the second access cycle, with data and error from flops
  assign pready = q_r.ack;
  assign prdata = q_r.rdata;
  assign pslverr = q_r.slverr;
  assign core_reset = (q_r.state != SRS_ST_RUN);
  assign smbus_enable = (q_r.state == SRS_ST_HALTED) || (q_r.state == SRS_ST_RUN);
  assign eeprom_init = (q_r.state == SRS_ST_RUN) && (q_r.mode == SRS_MODE_EEPROM);
  assign mode_reserved = (q_r.state != SRS_ST_RESET) && (q_r.mode > SRS_MODE_EEPROM);
  assign smbus_clk_tick = q_r.tick;
endmodule
`default_nettype wire

/* File: dv/srs_asserts.sv */
// Purpose: port checks for srs_top
// Assumes: straps stay put after release
// Notes: tick spacing is counted in gap_r
`timescale 1ns/10ps
`default_nettype none
module srs_asserts
  import srs_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic fundamental_reset_n, // in
  input wire logic reset_halt, // in
  input wire logic [2:0] switch_mode_strap, // in
  input wire logic master_smbus_slow_strap, // in
  input wire logic penable, // in
  input wire logic pwrite, // in
  input wire logic core_reset, // out
  input wire logic smbus_enable, // out
  input wire logic eeprom_init, // out
  input wire logic mode_reserved, // out
  input wire logic smbus_clk_tick // out
);
  logic [11:0] gap_r; // cycles since last tick, fff until one is seen
  // saturating, so the first tick after any reset is never judged
  always_ff @(posedge core_clk) begin
    if (rst || !fundamental_reset_n)
      gap_r <= 12'hfff;
    else if (smbus_clk_tick)
      gap_r <= 12'h000;
    else if (gap_r != 12'hfff)
      gap_r <= gap_r + 12'h001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  frn_hold_a: assert property (!fundamental_reset_n |=> core_reset && !smbus_enable) else $error("no reset hold");
  rst_hold_a: assert property (disable iff (1'b0) rst |=> core_reset && !smbus_enable)
    else $error("no rst hold");
  run_after_a: assert property ($rose(fundamental_reset_n) && !reset_halt |-> ##[15:18] !core_reset) else $error("no run");
  halt_enter_a: assert property ($rose(smbus_enable) |-> core_reset == reset_halt) else $error("bad halt");
  halt_stay_a: assert property (smbus_enable && core_reset && !(penable && pwrite) && !$past(penable && pwrite) |=> core_reset) else $error("left");
  tick_gap_a: assert property (smbus_clk_tick && gap_r != 12'hfff |->
    gap_r == (master_smbus_slow_strap ? SRS_SLOW_HALF : SRS_FAST_HALF) - 12'h001) else $error("bad tick gap");
  eeprom_a: assert property (!core_reset |-> eeprom_init == (switch_mode_strap == SRS_MODE_EEPROM)) else $error("eep");
  reserved_a: assert property (!core_reset |-> mode_reserved == (switch_mode_strap > 3'h1)) else $error("rsv");
  cover property ($fell(core_reset) && $past(smbus_enable));
  cover property (smbus_clk_tick && gap_r != 12'hfff && master_smbus_slow_strap);
  cover property (mode_reserved && !core_reset);
endmodule
bind srs_top srs_asserts u_srs_asserts (.*);
`default_nettype wire

/* File: dv/srs_board.sv */
// Purpose: board reset logic and strap resistors
// Assumes: hold and cfg come from the bench
// Notes: cfg[8:2] is {mode, slow, up cc, down cc, halt}
`timescale 1ns/10ps
`default_nettype none
module srs_board (
  input wire logic core_clk, // clock
  input wire logic hold, // keep reset asserted
  input wire logic [8:0] cfg, // strap set
  output var logic fundamental_reset_n = 1'b0, // to switch
  output var logic reset_halt = 1'b0, // strap
  output var logic [2:0] switch_mode_strap = 3'h0, // strap
  output var logic master_smbus_slow_strap = 1'b0, // strap
  output var logic upstream_common_clock_strap = 1'b0, // strap
  output var logic downstream_common_clock_strap = 1'b0 // strap
);
  // straps move only once reset is seen low, so they never change after release
  always @(posedge core_clk) begin
    fundamental_reset_n <= !hold;
    if (!fundamental_reset_n)
      {switch_mode_strap, master_smbus_slow_strap, upstream_common_clock_strap,
        downstream_common_clock_strap, reset_halt} <= cfg[8:2];
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: self-checking bench for srs_top
// Assumes: board model drives reset and straps
// Notes: rows hold straps beside the outputs they give
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("BAD t=%0t %h %h", $time, a, e); end end
module testbench
  import srs_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, hold = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, a;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] cfg = 9'h000, r;
  logic [8:0] rows [4] = '{9'h00c, 9'h072, 9'h09d, 9'h1e1}; // mode slow upcc dncc halt eep rsv
  logic [2:0] switch_mode_strap;
  logic fundamental_reset_n, reset_halt, master_smbus_slow_strap;
  logic upstream_common_clock_strap, downstream_common_clock_strap;
  logic pready, pslverr, core_reset, smbus_enable, eeprom_init, mode_reserved, smbus_clk_tick, err, e;
  int fails = 0, n_tests = 0, n;
  srs_board u_srs_board (.*);
  srs_top u_srs_top (.*);
  initial forever #2 core_clk = ~core_clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for the enable (sel 0) or a tick (sel 1)
  task automatic wait_for(input bit sel, input int lim, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while ((sel ? smbus_clk_tick : smbus_enable) !== 1'b1 && c < lim);
    if (c == lim) begin
      fails++;
      end_of_test();
    end
  endtask
  // one apb transfer; data and error are taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      cfg <= r;
      hold <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK(core_reset, 1'b1)
      hold <= 1'b0;
      wait_for(1'b0, 100, n);
      `CHK(core_reset, r[2])
      apb(1'b1, SRS_STRAP_OFF, 32'hffffffff);
      apb(1'b0, SRS_STRAP_OFF, 32'h0);
      `CHK({rd[12], rd[6:0]}, {r[0], r[2], r[3], r[4], r[5], r[8:6]})
      for (int p = 0; p <= SRS_NUM_DS; p++) begin
        a = SRS_USLS_OFF + 12'(4 * p);
        e = (p == 0) ? r[4] : r[3];
        apb(1'b0, a, 32'h0);
        `CHK(rd[SRS_SCLK_BIT], e)
        apb(1'b1, a, 32'(!e) << SRS_SCLK_BIT);
        apb(1'b0, a, 32'h0);
        `CHK(rd[SRS_SCLK_BIT], !e)
      end
      if (r[2]) begin
        apb(1'b1, SRS_SWITCH_CONTROL_REG_OFF, 32'h1);
        `CHK(core_reset, 1'b1)
        apb(1'b1, SRS_SWITCH_CONTROL_REG_OFF, 32'h0);
        repeat (2) @(posedge core_clk);
        `CHK(core_reset, 1'b0)
      end
      `CHK({eeprom_init, mode_reserved}, r[1:0])
      wait_for(1'b1, 3000, n);
      wait_for(1'b1, 3000, n);
      `CHK(n, r[5] ? int'(SRS_SLOW_HALF) : int'(SRS_FAST_HALF))
    end
    apb(1'b0, 12'h100, 32'h0);
    `CHK(err, 1'b1)
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1 `CHK({core_reset, smbus_enable}, 2'b10)
    end_of_test();
  end
endmodule
`default_nettype wire
